//--- fci_pkg.sv
/*
 * Shared constants, types and bus timing for the host-side flash
 * command controller.
 * Assumes a 40 MHz single clock and a x16 parallel flash on the far side.
 */
package fci_pkg;

    // ============================================================
    // Bus widths and address fields
    localparam int ADDR_W   = 20;   // Word address width
    localparam int DATA_W   = 16;   // Word data width
    localparam int BLK_LSB  = 15;   // 32 Kword (64 Kbyte) block base bit
    localparam int BANK_BIT = 19;   // Top bit splits the two banks
    localparam int UNLK_HI  = 11;   // Address bits from here up are don't-care
    localparam int TOG_BIT  = 6;    // Status bit that toggles while busy

    // ============================================================
    // Unlock cycles and command codes
    localparam logic [ADDR_W-1:0] UNLK_A1   = 20'h0_0555;
    localparam logic [ADDR_W-1:0] UNLK_A2   = 20'h0_02AA;
    localparam logic [ADDR_W-1:0] ID_PROT_A = 20'h0_0002; // Protect flag offset
    localparam logic [DATA_W-1:0] UNLK_D1   = 16'h00AA;
    localparam logic [DATA_W-1:0] UNLK_D2   = 16'h0055;
    localparam logic [DATA_W-1:0] CODE_PROG = 16'h00A0;
    localparam logic [DATA_W-1:0] CODE_ERS  = 16'h0080;
    localparam logic [DATA_W-1:0] CODE_BLK  = 16'h0030;
    localparam logic [DATA_W-1:0] CODE_CHIP = 16'h0010;
    localparam logic [DATA_W-1:0] CODE_ID   = 16'h0090;
    localparam logic [DATA_W-1:0] CODE_EXIT = 16'h00F0;
    localparam logic [DATA_W-1:0] CODE_SUSP = 16'h00B0;
    localparam logic [DATA_W-1:0] CODE_RES  = 16'h0030;

    // ============================================================
    // Write counts per command, unlock cycles included
    localparam logic [2:0] NWR_PROG = 3'h4;
    localparam logic [2:0] NWR_ERS  = 3'h6;
    localparam logic [2:0] NWR_ID   = 3'h4;
    localparam logic [2:0] NWR_CMD  = 3'h3;

    // ============================================================
    // Bus cycle phases, in clock cycles
    localparam logic [2:0] WE_FIRST = 3'h1;  // First phase with write strobe low
    localparam logic [2:0] WE_LAST  = 3'h2;  // Last phase with write strobe low
    localparam logic [2:0] WR_LAST  = 3'h3;  // Final phase of a write cycle
    localparam logic [2:0] RD_LAST  = 3'h3;  // Sample phase of a read cycle

    // ============================================================
    // Times and derived cycle counts
    localparam int CLK_NS      = 25;
    localparam int SUSP_STD_NS = 10000;  // Suspend latency, standard parts
    localparam int SUSP_LOW_NS = 1000;   // Suspend latency, low latency parts
    localparam int HWRST_NS    = 500;    // Reset pin low time
    localparam logic [15:0] SUSP_STD_CYC = 16'(SUSP_STD_NS / CLK_NS);
    localparam logic [15:0] SUSP_LOW_CYC = 16'(SUSP_LOW_NS / CLK_NS);
    localparam logic [7:0]  HWRST_CYC    = 8'((HWRST_NS + CLK_NS - 1) / CLK_NS);

    // ============================================================
    // Types
    typedef enum logic [3:0] {
        CMD_READ  = 4'h0,  // Array read
        CMD_PROG  = 4'h1,  // Program one word
        CMD_BLKER = 4'h2,  // Block erase start
        CMD_CHIP  = 4'h3,  // Chip erase start
        CMD_ID    = 4'h4,  // Protection status of a block
        CMD_SUSP  = 4'h5,  // Erase suspend
        CMD_RES   = 4'h6,  // Erase resume
        CMD_POLL  = 4'h7,  // One busy check of a running erase
        CMD_HWRST = 4'h8   // Pulse the reset pin
    } fci_cmd_t;

    typedef enum logic [4:0] {
        S_IDLE  = 5'b0_0001,
        S_WRITE = 5'b0_0010,
        S_READ  = 5'b0_0100,
        S_NEXT  = 5'b0_1000,
        S_HWRST = 5'b1_0000
    } fci_state_t;

    typedef struct packed {
        fci_cmd_t          cmd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fci_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fci_step_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;      // Address pins
        logic [DATA_W-1:0] dq;        // Data pins, outgoing value
        logic              dqOeN;     // Low while the data pins are driven
        logic              ceN;       // Chip enable
        logic              oeN;       // Output enable
        logic              weN;       // Write enable
        logic              rstN;      // Reset pin
        logic              unprotect; // Temporary unprotect request level
    } fci_pins_t;

endpackage

//--- fci_host.sv
/*
 * Host controller that drives a parallel flash through bus read and
 * bus write cycles and the reset pin: unlock sequences, program, erase, suspend,
 * resume, protection query and reset pin pulses.
 * Assumes flash data pins are synchronous to mclk and that the flash
 * answers status polling with a toggling busy bit.
 */
`timescale 1ns/100ps

module fci_host (
    input  wire logic              mclk,
    input  wire logic              rstn,
    input  wire fci_pkg::fci_req_t req,
    input  wire logic              reqValid,
    output logic                   reqReady,
    input  wire logic              lowLatency,
    input  wire logic              tempUnprotect,
    output logic                   rspValid,
    output logic                   rspError,
    output logic [15:0]            rspData,
    output logic                   eraseActive,
    output logic                   suspended,
    output fci_pkg::fci_pins_t     flOut,
    input  wire logic [15:0]       flDqIn
);
    import fci_pkg::*;

    // ============================================================
    // State
    fci_state_t        state_r;     // Sequencer state
    fci_req_t          cur_r;       // Request in progress
    logic [2:0]        ph_r;        // Phase within a bus cycle
    logic [2:0]        idx_r;       // Writes done in this sequence
    logic [1:0]        rdCnt_r;     // Reads done, saturating
    logic              lastTog_r;   // Busy bit of newest read
    logic              prevTog_r;   // Busy bit of the read before
    logic [15:0]       waitCnt_r;   // Cycles spent polling a suspend
    logic [7:0]        hwCnt_r;     // Reset pin low counter
    logic              bank_r;      // Bank of the running erase
    logic [4:0]        blk_r;       // Block of the running erase
    fci_pins_t         pins_r;      // Registered pin levels

    // ============================================================
    // Step table: address and data of write number idx
    function automatic fci_step_t stepOf(input fci_req_t r, input logic [2:0] i);
        fci_step_t s;
        s = '{addr: UNLK_A1, data: UNLK_D1};
        case (i)
            3'h0: s = '{addr: UNLK_A1, data: UNLK_D1};
            3'h1: s = '{addr: UNLK_A2, data: UNLK_D2};
            3'h2: begin
                case (r.cmd)
                    CMD_PROG: s.data = CODE_PROG;
                    CMD_BLKER, CMD_CHIP: s.data = CODE_ERS;
                    CMD_ID: s.data = CODE_ID;
                    CMD_SUSP: s.data = CODE_SUSP;
                    default: s.data = CODE_RES;
                endcase
            end
            3'h3: begin
                if (r.cmd == CMD_PROG) begin
                    s = '{addr: r.addr, data: r.data};
                end else if (r.cmd == CMD_ID) begin
                    s.data = CODE_EXIT;                         // Back to array read
                end
            end
            3'h4: s = '{addr: UNLK_A2, data: UNLK_D2};
            default: begin
                if (r.cmd == CMD_BLKER) begin
                    s = '{addr: {r.addr[ADDR_W-1:BLK_LSB], 15'h0000}, data: CODE_BLK};
                end else begin
                    s.data = CODE_CHIP;
                end
            end
        endcase
        return s;
    endfunction

    // ============================================================
    // Decode of the current sequence
    wire fci_step_t  step     = stepOf(cur_r, idx_r);
    wire logic [2:0] nWr      = (cur_r.cmd == CMD_PROG) ? NWR_PROG :
                                (cur_r.cmd == CMD_BLKER || cur_r.cmd == CMD_CHIP) ? NWR_ERS :
                                (cur_r.cmd == CMD_ID) ? NWR_ID :
                                (cur_r.cmd == CMD_READ || cur_r.cmd == CMD_POLL) ? 3'h0 : NWR_CMD;
    wire logic       stable   = (rdCnt_r == 2'h2) && (lastTog_r == prevTog_r);
    wire logic [15:0] suspLim = lowLatency ? SUSP_LOW_CYC : SUSP_STD_CYC;
    wire logic       suspLate = (cur_r.cmd == CMD_SUSP) && (waitCnt_r > suspLim);
    wire logic       idRead   = (cur_r.cmd == CMD_ID) && (idx_r == 3'h3) && (rdCnt_r == 2'h0);
    wire logic       wrEnd    = (state_r == S_WRITE) && (ph_r == WR_LAST);
    wire logic       rdEnd    = (state_r == S_READ) && (ph_r == RD_LAST);

    // Refusals; the flash would answer status, so reads into bank_r while the erase runs, or into blk_r while suspended, are held off
    wire logic running  = eraseActive && !suspended;
    wire logic sameBank = req.addr[BANK_BIT] == bank_r;
    wire logic sameBlk  = req.addr[ADDR_W-1:BLK_LSB] == blk_r;
    wire logic badRead  = eraseActive && ((running && sameBank) || (suspended && sameBlk));
    wire logic refuse   = (req.cmd == CMD_READ || req.cmd == CMD_ID || req.cmd == CMD_PROG)
                            ? badRead :
                          (req.cmd == CMD_BLKER || req.cmd == CMD_CHIP) ? eraseActive :
                          (req.cmd == CMD_SUSP || req.cmd == CMD_POLL) ? !running :
                          (req.cmd == CMD_RES) ? !suspended :
                          (req.cmd == CMD_HWRST) ? 1'b0 : 1'b1;
    wire logic take     = (state_r == S_IDLE) && reqValid;

    // NEXT decisions; after a read the writes go on from idx_r, not from the first unlock
    wire logic needRead = idRead ||
                          (cur_r.cmd == CMD_READ && rdCnt_r == 2'h0) ||
                          (cur_r.cmd == CMD_POLL && rdCnt_r != 2'h2);
    wire logic needPoll = (cur_r.cmd == CMD_PROG || cur_r.cmd == CMD_SUSP) && !stable;
    wire logic goWrite  = !needRead && (idx_r < nWr);
    wire logic goRead   = needRead || (!goWrite && needPoll && !suspLate);
    wire logic finish   = (state_r == S_NEXT) && !goWrite && !goRead;

    // Pin next values; the unprotect request has its own pin, apart from the reset pin
    wire logic       hwLow  = (state_r == S_HWRST) && (hwCnt_r != 8'h00);
    wire fci_pins_t  pinNxt = '{
        addr:      (state_r == S_READ && idRead) ? {cur_r.addr[ADDR_W-1:BLK_LSB], 15'h0002} :
                   (state_r == S_READ) ? cur_r.addr :
                   (state_r == S_WRITE) ? step.addr : pins_r.addr,
        dq:        (state_r == S_WRITE) ? step.data : pins_r.dq,
        dqOeN:     (state_r != S_WRITE),
        ceN:       (state_r != S_WRITE) && (state_r != S_READ),
        oeN:       (state_r != S_READ),
        weN:       !(state_r == S_WRITE && ph_r >= WE_FIRST && ph_r <= WE_LAST),
        rstN:      !hwLow,
        unprotect: tempUnprotect
    };

    // ============================================================
    // Pin register; reset holds the flash in reset too
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pins_r <= '{addr: '0, dq: '0, dqOeN: 1'b1, ceN: 1'b1, oeN: 1'b1,
                        weN: 1'b1, rstN: 1'b0, unprotect: 1'b0};
        end else begin
            pins_r <= pinNxt;
        end
    end

    // Sequencer
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_r <= S_IDLE;
            ph_r    <= 3'h0;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (take && !refuse) begin
                        state_r <= (req.cmd == CMD_HWRST) ? S_HWRST : S_NEXT;
                    end
                end
                S_WRITE, S_READ: begin
                    ph_r <= (wrEnd || rdEnd) ? 3'h0 : ph_r + 3'h1;
                    if (wrEnd || rdEnd) begin
                        state_r <= S_NEXT;
                    end
                end
                S_NEXT: begin
                    state_r <= goWrite ? S_WRITE : goRead ? S_READ : S_IDLE;
                end
                S_HWRST: begin
                    if (hwCnt_r == 8'h00) begin
                        state_r <= S_IDLE;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // Sequence counters and the status toggle history
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cur_r     <= '{cmd: CMD_READ, addr: '0, data: '0};
            idx_r     <= 3'h0;
            rdCnt_r   <= 2'h0;
            lastTog_r <= 1'b0;
            prevTog_r <= 1'b0;
            waitCnt_r <= 16'h0000;
            hwCnt_r   <= 8'h00;
        end else begin
            if (take) begin
                cur_r     <= req;
                idx_r     <= 3'h0;
                rdCnt_r   <= 2'h0;
                waitCnt_r <= 16'h0000;
                hwCnt_r   <= HWRST_CYC;
            end
            if (wrEnd) begin
                idx_r <= idx_r + 3'h1;
            end
            if (rdEnd) begin
                rdCnt_r   <= (rdCnt_r == 2'h2) ? 2'h2 : rdCnt_r + 2'h1;
                prevTog_r <= lastTog_r;
                lastTog_r <= flDqIn[TOG_BIT];
            end
            if (state_r != S_IDLE && cur_r.cmd == CMD_SUSP && !suspLate) begin
                waitCnt_r <= waitCnt_r + 16'h0001;
            end
            if (hwLow) begin
                hwCnt_r <= hwCnt_r - 8'h01;
            end
        end
    end

    // Answer and erase bookkeeping
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rspValid    <= 1'b0;
            rspError    <= 1'b0;
            rspData     <= 16'h0000;
            eraseActive <= 1'b0;
            suspended   <= 1'b0;
            bank_r      <= 1'b0;
            blk_r       <= 5'h00;
        end else begin
            rspValid <= (take && refuse) || finish || (state_r == S_HWRST && hwCnt_r == 8'h00);
            rspError <= (take && refuse) || (finish && suspLate);
            if (rdEnd && (cur_r.cmd == CMD_READ || idRead)) begin
                rspData <= idRead ? {15'h0000, flDqIn[0]} : flDqIn;
            end else if (finish && cur_r.cmd == CMD_POLL) begin
                rspData <= {15'h0000, !stable};
            end
            if (finish && (cur_r.cmd == CMD_BLKER || cur_r.cmd == CMD_CHIP)) begin
                eraseActive <= 1'b1;
                bank_r      <= cur_r.addr[BANK_BIT];
                blk_r       <= (cur_r.cmd == CMD_CHIP) ? 5'h1F : cur_r.addr[ADDR_W-1:BLK_LSB];
            end
            if (finish && cur_r.cmd == CMD_POLL && stable) begin
                eraseActive <= 1'b0;
            end
            if (finish && cur_r.cmd == CMD_SUSP && !suspLate) begin
                suspended <= 1'b1;
            end
            if (finish && cur_r.cmd == CMD_RES) begin
                suspended <= 1'b0;
            end
            if (state_r == S_HWRST) begin
                eraseActive <= 1'b0;
                suspended   <= 1'b0;
            end
        end
    end

    assign reqReady = state_r[0];   // Idle bit of the one-hot state flop
    assign flOut    = pins_r;

    // ============================================================
    // Checks
    strobeExcl_a: assert property (@(posedge mclk) disable iff (!rstn)
        !(!flOut.weN && !flOut.oeN)) else $error("write and read strobes low together");
    noContend_a: assert property (@(posedge mclk) disable iff (!rstn)
        !flOut.oeN |-> flOut.dqOeN) else $error("data driven during read");
    unlockFirst_a: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(flOut.weN) && idx_r == 3'h0 |-> flOut.addr == UNLK_A1 && flOut.dq == UNLK_D1)
        else $error("first unlock write wrong");
    unlockSecond_a: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(flOut.weN) && idx_r == 3'h1 |-> flOut.addr == UNLK_A2 && flOut.dq == UNLK_D2)
        else $error("second unlock write wrong");
    unlockHigh_a: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(flOut.weN) && idx_r < 3'h3 |-> flOut.addr[ADDR_W-1:UNLK_HI] == '0)
        else $error("unlock high address bits set");
    eraseAlign_a: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(flOut.weN) && cur_r.cmd == CMD_BLKER && idx_r == 3'h5 |->
        flOut.addr[BLK_LSB-1:0] == '0 && flOut.dq == CODE_BLK)
        else $error("block erase not block aligned");
    busyRead_a: assert property (@(posedge mclk) disable iff (!rstn)
        take && req.cmd == CMD_READ && running && sameBank |=> rspValid && rspError
        ##1 flOut.oeN) else $error("read of busy bank not refused");
    suspLimit_a: assert property (@(posedge mclk) disable iff (!rstn)
        finish && suspLate |=> rspError && !suspended) else $error("late suspend not flagged");
    hwPulse_a: assert property (@(posedge mclk) disable iff (!rstn)
        hwLow |=> !flOut.rstN && !eraseActive) else $error("reset pin not low");
    rspPulse_a: assert property (@(posedge mclk) disable iff (!rstn)
        rspValid |=> !rspValid) else $error("answer longer than one cycle");

endmodule

//--- fci_flash_model.sv
/* Behavioural parallel flash facing the host controller: unlock decode,
   program, block and chip erase, suspend, resume and protect query.
   Assumes flash pins change only on mclk edges; timings are in cycles. */
`timescale 1ns/100ps
module fci_flash_model #(
    parameter int ERS_CYC  = 600, // Erase length
    parameter int SUSP_CYC = 12,  // Suspend settle, inside the 1 us limit
    parameter int PROT_BLK = 3    // Block marked protected
) (
    input  wire logic               mclk,
    input  wire fci_pkg::fci_pins_t pins,
    output logic [15:0]             dqOut
);
    import fci_pkg::*;
    // ============================================================
    // Array and command state
    logic [15:0] mem [int];          // Written words, absent = erased
    int          q [$];              // Keys to clear
    int          step = 0;           // Position in write sequence
    int          ersLeft = 0;        // Erase cycles left, kept over suspend
    int          suspCnt = 0;        // Cycles until suspend settles
    int          progLeft = 0;       // Program busy cycles
    int          ersBlk = 0;         // Erased block, -1 whole chip
    logic        eBank, pBank;       // Banks of running work
    logic        susp = 1'h0;        // Erase suspended
    logic        idMode = 1'h0;      // Identification read mode
    logic        tog = 1'h0;         // Busy bit, flips each read while work runs
    logic        weD = 1'h1;         // Write strobe one cycle ago
    logic        oeD = 1'h1;         // Output enable one cycle ago
    logic        bankHit, blkHit;    // Read hits busy bank or block
    logic [19:0] wa = '0;            // Captured write address
    logic [15:0] wd = '0;            // Captured write data
    logic [15:0] rv;                 // Read value
    wire         un1 = wa[10:0] == UNLK_A1[10:0] && wd == UNLK_D1;
    wire         un2 = wa[10:0] == UNLK_A2[10:0] && wd == UNLK_D2;
    wire         lock = wa[19:15] == 5'(PROT_BLK) && !pins.unprotect;
    initial dqOut = '0;
    // ============================================================
    // One pass a cycle: erase progress, write decode, read data
    always @(posedge mclk) begin
        if (progLeft > 0) progLeft--;
        if (susp && suspCnt > 0) suspCnt--; // Halt settles
        if (ersLeft > 0 && !susp) begin
            ersLeft--;
            if (ersLeft == 0) begin // Whole blocks only
                foreach (mem[k])
                    if (k >> 15 == ersBlk || (ersBlk < 0 && k >> 15 != PROT_BLK))
                        q.push_back(k);
                foreach (q[j]) mem.delete(q[j]);
                q.delete();
            end
        end
        if (!pins.weN && !pins.ceN) begin
            wa = pins.addr;
            wd = pins.dq;
        end
        // Writes go to the sequence decoder, never straight to the array
        if (!weD && pins.weN) begin
            if (wd == CODE_EXIT) idMode = 1'h0;
            case (step)
                0, 3: step = un1 ? step + 1 : 0; // Slip restarts
                1, 4: step = un2 ? step + 1 : 0;
                2: begin
                    step = wa[10:0] != UNLK_A1[10:0] ? 0 : wd == CODE_PROG ? 6 :
                           wd == CODE_ERS ? 3 : 0;
                    if (wd == CODE_ID) idMode = 1'h1;
                    if (wd == CODE_SUSP && ersLeft > 0) begin // Any time in erase
                        susp = 1'h1;
                        suspCnt = SUSP_CYC;
                    end
                    if (wd == CODE_RES) susp = 1'h0; // Count left untouched
                end
                5: begin
                    step = 0;
                    if (wd == CODE_CHIP || (wd == CODE_BLK && !lock)) begin
                        ersBlk = wd == CODE_CHIP ? -1 : int'(wa[19:15]);
                        eBank = wa[19];
                        ersLeft = ERS_CYC;
                    end
                end
                6: begin
                    step = 0;
                    if (!lock) begin // Programming only clears bits
                        mem[wa] = (mem.exists(wa) ? mem[wa] : 16'hFFFF) & wd;
                        progLeft = 8;
                        pBank = wa[19];
                    end
                end
                default: step = 0;
            endcase
        end
        // Busy bit moves only while work runs, so a settled suspend polls stable
        if (!pins.oeN && oeD && (progLeft > 0 || (ersLeft > 0 && !(susp && suspCnt == 0))))
            tog = ~tog;
        bankHit = ersBlk < 0 || pins.addr[19] == eBank;
        blkHit = ersBlk < 0 || int'(pins.addr[19:15]) == ersBlk;
        rv = mem.exists(pins.addr) ? mem[pins.addr] : 16'hFFFF;
        if (idMode && pins.addr[14:0] == 15'h0002)
            rv = {15'h0000, pins.addr[19:15] == 5'(PROT_BLK)};
        else if ((progLeft > 0 && pins.addr[19] == pBank) ||
                 (ersLeft > 0 && (susp && suspCnt == 0 ? blkHit : bankHit)))
            rv = {9'h000, tog, 6'h00}; // Status in place of array
        // Released bus keeps moving so a stale value never passes
        dqOut <= (!pins.ceN && !pins.oeN) ? rv : ~dqOut;
        weD = pins.weN;
        oeD = pins.oeN;
        if (!pins.rstN) begin // Pin low aborts work, back to read
            step = 0;
            idMode = 1'h0;
            susp = 1'h0;
            ersLeft = 0;
            progLeft = 0;
        end
    end
endmodule

//--- testbench.sv
/* Self-checking bench: host controller against the flash model.
   Assumes the model settles suspend well inside the low latency limit. */
`timescale 1ns/100ps
module testbench;
    import fci_pkg::*;
    // ============================================================
    // Clock, stimulus and expected array
    logic        mclk = 1'h0, rstn = 1'h0, reqValid = 1'h0;
    logic        lowLatency = 1'h0, tempUnprotect = 1'h0;
    fci_req_t    req = '0;
    logic        reqReady, rspValid, rspError, eraseActive, suspended, er;
    logic [15:0] rspData, flDqIn, rd, d;
    logic [19:0] a, a0;
    fci_pins_t   flOut;
    logic [15:0] ex [int];          // Expected array, absent = erased
    int          q [$];
    int          error_cnt = 0, n_checks = 0, cyc = 0, i;
    always #12.5 mclk = ~mclk;
    fci_host dut (.mclk(mclk), .rstn(rstn), .req(req), .reqValid(reqValid),
        .reqReady(reqReady), .lowLatency(lowLatency), .tempUnprotect(tempUnprotect),
        .rspValid(rspValid), .rspError(rspError), .rspData(rspData),
        .eraseActive(eraseActive), .suspended(suspended), .flOut(flOut), .flDqIn(flDqIn));
    fci_flash_model #(.PROT_BLK(3)) flash (.mclk(mclk), .pins(flOut), .dqOut(flDqIn));
    // ============================================================
    // Bus tasks and comparison
    task automatic run(input fci_cmd_t c, input logic [19:0] ad, input logic [15:0] dt);
        int k;
        @(negedge mclk);
        req = '{cmd: c, addr: ad, data: dt};
        reqValid = 1'h1;
        for (k = 0; k < 3000 && reqReady !== 1'h1; k++) @(negedge mclk);
        @(negedge mclk);
        reqValid = 1'h0;
        for (k = 0; k < 3000 && rspValid !== 1'h1; k++) @(negedge mclk);
        rd = rspData;
        er = rspError;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] want, input string m);
        n_checks++;
        if (got !== want) begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %h want %h", $time, m, got, want);
        end
    endtask
    function automatic logic [15:0] ev(input logic [19:0] x);
        return ex.exists(x) ? ex[x] : 16'hFFFF;
    endfunction
    task automatic wipe(input int b); // Block b erased, -1 all but protected
        foreach (ex[k])
            if (k >> 15 == b || (b < 0 && k >> 15 != 3))
                q.push_back(k);
        foreach (q[j]) ex.delete(q[j]);
        q.delete();
    endtask
    task automatic drain(input logic [19:0] ad); // Poll until erase seen done
        for (int k = 0; k < 300 && eraseActive === 1'h1; k++) run(CMD_POLL, ad, '0);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin // Hang guard
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim;
        end
    end
    // ============================================================
    // Main sequence
    initial begin
        void'($urandom(8));
        repeat (8) @(posedge mclk);
        @(negedge mclk) rstn = 1'h1;
        for (i = 0; i < 6; i++) begin
            a = {5'h01, 15'($urandom)};
            d = 16'($urandom);
            if (i == 0) a0 = a;
            run(CMD_PROG, a, d);
            ex[a] = ev(a) & d;
            run(CMD_READ, a, '0);
            chk(rd, ev(a), "program readback");
        end
        $display("test program done");
        a = {5'h03, 15'h0100};
        run(CMD_PROG, a, 16'h1234);
        run(CMD_READ, a, '0);
        chk(rd, 16'hFFFF, "protected block changed");
        run(CMD_ID, a, '0);
        chk(rd & 16'h0001, 16'h0001, "protect flag");
        run(CMD_ID, a0, '0);
        chk(rd & 16'h0001, 16'h0000, "unprotected flag");
        tempUnprotect = 1'h1;
        run(CMD_PROG, a, 16'h1234);
        ex[a] = 16'h1234;
        tempUnprotect = 1'h0;
        run(CMD_READ, a, '0);
        chk(rd, 16'h1234, "temporary unprotect");
        $display("test protect done");
        for (i = 0; i < 2; i++) begin
            lowLatency = i[0];
            run(CMD_BLKER, 20'h0_8000, '0);
            chk({15'h0000, er}, 16'h0000, "erase start");
            run(CMD_READ, a0, '0);
            chk({15'h0000, er}, 16'h0001, "busy bank read");
            run(CMD_READ, 20'h8_0010, '0);
            chk(rd, ev(20'h8_0010), "other bank read");
            run(CMD_POLL, 20'h0_8000, '0);
            chk(rd & 16'h0001, 16'h0001, "erase busy");
            run(CMD_SUSP, 20'h0_8000, '0);
            chk({14'h0000, er, suspended}, 16'h0001, "suspend latency");
            run(CMD_READ, a, '0);
            chk(rd, ev(a), "read while suspended");
            run(CMD_RES, 20'h0_8000, '0);
            chk({15'h0000, er}, 16'h0000, "resume");
            drain(20'h0_8000);
            wipe(1);
            run(CMD_READ, a0, '0);
            chk(rd, ev(a0), "erased block");
        end
        $display("test suspend done");
        run(CMD_RES, '0, '0);
        chk({15'h0000, er}, 16'h0001, "resume refused");
        run(fci_cmd_t'(4'hF), '0, '0);
        chk({15'h0000, er}, 16'h0001, "unknown refused");
        run(CMD_CHIP, '0, '0);
        drain('0);
        wipe(-1);
        run(CMD_READ, a, '0);
        chk(rd, ev(a), "chip erase spares protected");
        run(CMD_BLKER, 20'h0_8000, '0);
        run(CMD_BLKER, 20'h0_8000, '0);
        chk({15'h0000, er}, 16'h0001, "second erase refused");
        run(CMD_HWRST, '0, '0);
        chk({15'h0000, eraseActive}, 16'h0000, "reset aborts");
        run(CMD_READ, a0, '0);
        chk({15'h0000, er}, 16'h0000, "read after reset");
        chk(rd, ev(a0), "array after reset");
        $display("test refuse done");
        end_sim;
    end
endmodule
